// ### common/scan_tap_consts.svh
// Constants for the scan test access port controller
`ifndef SCAN_TAP_CONSTS_SVH
`define SCAN_TAP_CONSTS_SVH
`define IR_WIDTH 8
`define IR_RESET 8'h81
`define IR_CAPTURE 8'h81
`define IR_PARITY_BIT 7
`define BCELL_WIDTH 48
`define BCELL_RESET_HI 4'h3
`define SEL_WIDTH 3
`define SEL_RESET 3'h2
`define ID_WIDTH 32
`define OPC_BYPASS 8'hFF
`define OPC_IDCODE 8'h81
`define OPC_SAMPLE 8'h82
`define OPC_EXTEST 8'h00
`define OPC_RUNT 8'h09
`define OPC_READSEL 8'h0A
`define OPC_SCANSEL 8'h8B
`endif

// ### common/scan_tap_pkg.sv
// Types for the scan test access port controller
package scan_tap_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;
  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_IDENT, SEL_CHAIN, SEL_EXTRA
  } dr_sel_t;
endpackage

// ### hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  logic s1_r, s2_r, s3_r, out_r;
  logic out_nxt;
  // Output moves only once stages two and three agree
  always_comb begin
    out_nxt = out_r;
    if (s2_r == s3_r) begin
      out_nxt = s2_r;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      out_r <= RESET_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end
  assign dout = out_r;
endmodule

// ### hdl/tap_fsm.sv
// Sixteen-state test access port controller
`timescale 1ns/1ps
module tap_fsm (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic step,
  input wire logic tms,
  output scan_tap_pkg::tap_state_t state
);
  scan_tap_pkg::tap_state_t state_r, state_nxt;
  always_comb begin
    state_nxt = state_r;
    if (step) begin
      case (state_r)
        scan_tap_pkg::TLR: state_nxt = tms ? scan_tap_pkg::TLR : scan_tap_pkg::RTI;
        scan_tap_pkg::RTI: state_nxt = tms ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RTI;
        scan_tap_pkg::SEL_DR: state_nxt = tms ? scan_tap_pkg::SEL_IR : scan_tap_pkg::CAP_DR;
        scan_tap_pkg::CAP_DR: state_nxt = tms ? scan_tap_pkg::EX1_DR : scan_tap_pkg::SHF_DR;
        scan_tap_pkg::SHF_DR: state_nxt = tms ? scan_tap_pkg::EX1_DR : scan_tap_pkg::SHF_DR;
        scan_tap_pkg::EX1_DR: state_nxt = tms ? scan_tap_pkg::UPD_DR : scan_tap_pkg::PAU_DR;
        scan_tap_pkg::PAU_DR: state_nxt = tms ? scan_tap_pkg::EX2_DR : scan_tap_pkg::PAU_DR;
        scan_tap_pkg::EX2_DR: state_nxt = tms ? scan_tap_pkg::UPD_DR : scan_tap_pkg::SHF_DR;
        scan_tap_pkg::UPD_DR: state_nxt = tms ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RTI;
        scan_tap_pkg::SEL_IR: state_nxt = tms ? scan_tap_pkg::TLR : scan_tap_pkg::CAP_IR;
        scan_tap_pkg::CAP_IR: state_nxt = tms ? scan_tap_pkg::EX1_IR : scan_tap_pkg::SHF_IR;
        scan_tap_pkg::SHF_IR: state_nxt = tms ? scan_tap_pkg::EX1_IR : scan_tap_pkg::SHF_IR;
        scan_tap_pkg::EX1_IR: state_nxt = tms ? scan_tap_pkg::UPD_IR : scan_tap_pkg::PAU_IR;
        scan_tap_pkg::PAU_IR: state_nxt = tms ? scan_tap_pkg::EX2_IR : scan_tap_pkg::PAU_IR;
        scan_tap_pkg::EX2_IR: state_nxt = tms ? scan_tap_pkg::UPD_IR : scan_tap_pkg::SHF_IR;
        scan_tap_pkg::UPD_IR: state_nxt = tms ? scan_tap_pkg::SEL_DR : scan_tap_pkg::RTI;
        default: state_nxt = scan_tap_pkg::TLR;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= scan_tap_pkg::TLR;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign state = state_r;
endmodule

// ### hdl/scan_tap_controller.sv
// Boundary-scan controller with instruction and data registers
// Contract
// - Sixteen states stepped by TMS on TCK rise
// - Power-up in reset state, test logic idle
// - TMS high five cycles reaches reset
// - Reset loads instruction 10000001
// - Cells 47-46 cleared, 45-44 set
// - Extra selector resets to 010
// - Selected operation runs only in idle
// - Scan-select states do nothing, exit next
// - Data capture loads on exiting rise
// - Shift-DR enables TDO on falling edge
// - Data shifts each rise after entry
// - Exit1-DR floats TDO; exits allow reshift
// - Data pause holds contents indefinitely
// - Data update latches on falling edge
// - Instruction capture loads 10000001
// - Shift-IR enables TDO, shifts each rise
// - Exit1-IR floats TDO; exits allow reshift
// - Instruction pause holds shifted bits
// - Instruction latched on Update-IR fall
// - Shift stage plus latch; bypass, ident none
// - Eight-bit instruction, even parity bit 7
// - Unsupported instructions act as bypass
// - Sample on TCK rise, outputs on fall
// - Chain 48, selector 3, bypass 1, ident 32
// - Bypass captures zero
`timescale 1ns/1ps
`include "scan_tap_consts.svh"
module scan_tap_controller #(
  parameter int CHAIN_W = `BCELL_WIDTH,
  parameter int SEL_W = `SEL_WIDTH,
  parameter logic [`ID_WIDTH-1:0] IDENT_VALUE = 32'h0000_0001
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  input wire logic [CHAIN_W-1:0] CHAIN_CAPTURE,
  output logic [CHAIN_W-1:0] CHAIN_OUT,
  output logic [SEL_W-1:0] EXTRA_SELECT,
  output logic [`IR_WIDTH-1:0] INSTRUCTION,
  output logic TEST_MODE,
  output logic RUN_OPERATION,
  output logic STATE_RESET
);
  // IDENT_VALUE is arbitrary, not a real maker code
  logic tck_s, tms_s, tdi_s;
  logic tck_d_r;
  logic rise, fall;
  scan_tap_pkg::tap_state_t state;
  scan_tap_pkg::dr_sel_t dr_sel;

  // Default high for an open TMS or TDI pin
  pin_sync #(.RESET_VAL(1'b0)) u_sync_tck (.clk(CLK), .arst_n(ARST_N), .din(TCK), .dout(tck_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sync_tms (.clk(CLK), .arst_n(ARST_N), .din(TMS), .dout(tms_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sync_tdi (.clk(CLK), .arst_n(ARST_N), .din(TDI), .dout(tdi_s));

  // TMS and TDI share the TCK latency, so samples stay aligned
  assign rise = tck_s & ~tck_d_r;
  assign fall = ~tck_s & tck_d_r;

  tap_fsm u_fsm (.clk(CLK), .arst_n(ARST_N), .step(rise), .tms(tms_s), .state(state));

  logic [`IR_WIDTH-1:0] ir_sh_r, ir_sh_nxt;
  logic [`IR_WIDTH-1:0] ir_lat_r, ir_lat_nxt;
  logic [CHAIN_W-1:0] ch_sh_r, ch_sh_nxt;
  logic [CHAIN_W-1:0] ch_lat_r, ch_lat_nxt;
  logic [SEL_W-1:0] sel_sh_r, sel_sh_nxt;
  logic [SEL_W-1:0] sel_lat_r, sel_lat_nxt;
  logic byp_r, byp_nxt;
  logic [`ID_WIDTH-1:0] id_sh_r, id_sh_nxt;
  logic tdo_r, tdo_nxt;
  logic oe_r, oe_nxt;
  logic parity_ok;
  logic dr_tail;

  // Odd-weight opcodes fail parity and fall back to bypass
  assign parity_ok = ~(^ir_lat_r);

  always_comb begin
    dr_sel = scan_tap_pkg::SEL_BYPASS;
    if (parity_ok) begin
      case (ir_lat_r)
        `OPC_IDCODE: dr_sel = scan_tap_pkg::SEL_IDENT;
        `OPC_SAMPLE: dr_sel = scan_tap_pkg::SEL_CHAIN;
        `OPC_EXTEST: dr_sel = scan_tap_pkg::SEL_CHAIN;
        `OPC_SCANSEL: dr_sel = scan_tap_pkg::SEL_EXTRA;
        `OPC_READSEL: dr_sel = scan_tap_pkg::SEL_EXTRA;
        `OPC_RUNT: dr_sel = scan_tap_pkg::SEL_BYPASS;
        default: dr_sel = scan_tap_pkg::SEL_BYPASS;
      endcase
    end
  end

  always_comb begin
    dr_tail = byp_r;
    case (dr_sel)
      scan_tap_pkg::SEL_IDENT: dr_tail = id_sh_r[0];
      scan_tap_pkg::SEL_CHAIN: dr_tail = ch_sh_r[0];
      scan_tap_pkg::SEL_EXTRA: dr_tail = sel_sh_r[0];
      default: dr_tail = byp_r;
    endcase
  end

  // Shift stages move on TCK rise
  always_comb begin
    ir_sh_nxt = ir_sh_r;
    ch_sh_nxt = ch_sh_r;
    sel_sh_nxt = sel_sh_r;
    byp_nxt = byp_r;
    id_sh_nxt = id_sh_r;
    if (rise) begin
      case (state)
        scan_tap_pkg::CAP_IR: ir_sh_nxt = `IR_CAPTURE;
        scan_tap_pkg::SHF_IR: ir_sh_nxt = {tdi_s, ir_sh_r[`IR_WIDTH-1:1]};
        scan_tap_pkg::CAP_DR: begin
          case (dr_sel)
            scan_tap_pkg::SEL_IDENT: id_sh_nxt = IDENT_VALUE;
            scan_tap_pkg::SEL_CHAIN: ch_sh_nxt = CHAIN_CAPTURE;
            scan_tap_pkg::SEL_EXTRA: sel_sh_nxt = sel_lat_r;
            default: byp_nxt = 1'b0;
          endcase
        end
        scan_tap_pkg::SHF_DR: begin
          case (dr_sel)
            scan_tap_pkg::SEL_IDENT: id_sh_nxt = {tdi_s, id_sh_r[`ID_WIDTH-1:1]};
            scan_tap_pkg::SEL_CHAIN: ch_sh_nxt = {tdi_s, ch_sh_r[CHAIN_W-1:1]};
            scan_tap_pkg::SEL_EXTRA: sel_sh_nxt = {tdi_s, sel_sh_r[SEL_W-1:1]};
            default: byp_nxt = tdi_s;
          endcase
        end
        // Pause and exit states hold every stage untouched
        default: ir_sh_nxt = ir_sh_r;
      endcase
    end
  end

  // Latches and TDO change on TCK fall
  always_comb begin
    ir_lat_nxt = ir_lat_r;
    ch_lat_nxt = ch_lat_r;
    sel_lat_nxt = sel_lat_r;
    tdo_nxt = tdo_r;
    oe_nxt = oe_r;
    if (fall) begin
      case (state)
        scan_tap_pkg::TLR: begin
          ir_lat_nxt = `IR_RESET;
          ch_lat_nxt[CHAIN_W-1 -: 4] = `BCELL_RESET_HI;
          sel_lat_nxt = `SEL_RESET;
          oe_nxt = 1'b0;
        end
        scan_tap_pkg::SHF_IR: begin
          tdo_nxt = ir_sh_r[0];
          oe_nxt = 1'b1;
        end
        scan_tap_pkg::SHF_DR: begin
          tdo_nxt = dr_tail;
          oe_nxt = 1'b1;
        end
        scan_tap_pkg::UPD_IR: ir_lat_nxt = ir_sh_r;
        scan_tap_pkg::UPD_DR: begin
          if (dr_sel == scan_tap_pkg::SEL_CHAIN) begin
            ch_lat_nxt = ch_sh_r;
          end
          if (dr_sel == scan_tap_pkg::SEL_EXTRA && ir_lat_r == `OPC_SCANSEL) begin
            sel_lat_nxt = sel_sh_r;
          end
          oe_nxt = 1'b0;
        end
        default: oe_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tck_d_r <= 1'b0;
      ir_sh_r <= `IR_RESET;
      ir_lat_r <= `IR_RESET;
      ch_sh_r <= '0;
      ch_lat_r <= {`BCELL_RESET_HI, {(CHAIN_W-4){1'b0}}};
      sel_sh_r <= `SEL_RESET;
      sel_lat_r <= `SEL_RESET;
      byp_r <= 1'b0;
      id_sh_r <= '0;
      tdo_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      tck_d_r <= tck_s;
      ir_sh_r <= ir_sh_nxt;
      ir_lat_r <= ir_lat_nxt;
      ch_sh_r <= ch_sh_nxt;
      ch_lat_r <= ch_lat_nxt;
      sel_sh_r <= sel_sh_nxt;
      sel_lat_r <= sel_lat_nxt;
      byp_r <= byp_nxt;
      id_sh_r <= id_sh_nxt;
      tdo_r <= tdo_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Test mode only for the EXTEST instruction, outside the reset state
  assign TEST_MODE = parity_ok && (ir_lat_r == `OPC_EXTEST) && (state != scan_tap_pkg::TLR);
  assign RUN_OPERATION = parity_ok && (ir_lat_r == `OPC_RUNT) && (state == scan_tap_pkg::RTI);
  assign STATE_RESET = (state == scan_tap_pkg::TLR);
  assign TDO = tdo_r;
  assign TDO_OE = oe_r;
  assign CHAIN_OUT = ch_lat_r;
  assign EXTRA_SELECT = sel_lat_r;
  assign INSTRUCTION = ir_lat_r;
endmodule

// ### bench/scan_tap_monitor.sv
// Port assertions for the scan controller
`timescale 1ns/1ps
module scan_tap_monitor #(
  parameter int CHAIN_W = 48,
  parameter int SEL_W = 3
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDO,
  input wire logic TDO_OE,
  input wire logic [CHAIN_W-1:0] CHAIN_OUT,
  input wire logic [SEL_W-1:0] EXTRA_SELECT,
  input wire logic [7:0] INSTRUCTION,
  input wire logic TEST_MODE,
  input wire logic RUN_OPERATION,
  input wire logic STATE_RESET
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic tck_r;
  logic [3:0] fall_cnt_r, fall_cnt_nxt;
  logic [2:0] ones_r, ones_nxt;
  // Raw pin edges; the design lags these by its synchroniser
  always_comb begin
    fall_cnt_nxt = (fall_cnt_r == 4'hF) ? 4'hF : fall_cnt_r + 4'h1;
    ones_nxt = ones_r;
    if (tck_r && !TCK) fall_cnt_nxt = 4'h0;
    if (!tck_r && TCK) ones_nxt = !TMS ? 3'h0 : (ones_r == 3'h5) ? 3'h5 : ones_r + 3'h1;
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tck_r <= 1'b0;
      fall_cnt_r <= 4'hF;
      ones_r <= 3'h0;
    end else begin
      tck_r <= TCK;
      fall_cnt_r <= fall_cnt_nxt;
      ones_r <= ones_nxt;
    end
  end
  sequence reset_vals;
    INSTRUCTION == 8'h81 && EXTRA_SELECT == 3'h2 && CHAIN_OUT[CHAIN_W-1 -: 4] == 4'h3;
  endsequence
  rst_vals_a: assert property ($rose(ARST_N) |-> reset_vals)
    else $error("reset values wrong");
  tlr_reload_a: assert property (STATE_RESET && fall_cnt_r == 4'h0 |-> ##[1:8] reset_vals)
    else $error("reset state reload missing");
  five_high_a: assert property (ones_r == 3'h5 |-> ##[0:8] STATE_RESET)
    else $error("five high TMS did not reset");
  run_idle_a: assert property (RUN_OPERATION |-> INSTRUCTION == 8'h09 && !STATE_RESET)
    else $error("operation outside idle");
  reset_quiet_a: assert property (STATE_RESET |-> !TEST_MODE && !TDO_OE)
    else $error("test logic active in reset");
  tdo_fall_a: assert property ($changed(TDO) || $changed(TDO_OE) |-> fall_cnt_r <= 4'h7)
    else $error("tdo changed away from fall");
  ir_fall_a: assert property ($changed(INSTRUCTION) |-> fall_cnt_r <= 4'h7)
    else $error("instruction changed away from fall");
  dr_fall_a: assert property ($changed(CHAIN_OUT) || $changed(EXTRA_SELECT) |-> fall_cnt_r <= 4'h7)
    else $error("latch changed away from fall");
  mode_decode_a: assert property (TEST_MODE |-> INSTRUCTION == 8'h00)
    else $error("test mode with wrong instruction");
endmodule
bind scan_tap_controller scan_tap_monitor #(.CHAIN_W(CHAIN_W), .SEL_W(SEL_W)) mon_i (.CLK(CLK), .ARST_N(ARST_N),
  .TCK(TCK), .TMS(TMS), .TDO(TDO), .TDO_OE(TDO_OE), .CHAIN_OUT(CHAIN_OUT), .EXTRA_SELECT(EXTRA_SELECT),
  .INSTRUCTION(INSTRUCTION), .TEST_MODE(TEST_MODE), .RUN_OPERATION(RUN_OPERATION), .STATE_RESET(STATE_RESET));

// ### bench/scan_host.sv
// External test controller model driving the test bus
`timescale 1ns/1ps
module scan_host (
  input wire logic clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One TCK period; TDO read late so the synchroniser lag is covered
  task automatic step(input logic m, input logic d, output logic q, output logic oe);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    // Eight CLK per TCK period, 200 ns
    repeat (3) @(posedge clk);
    @(negedge clk);
    q = tdo;
    oe = tdo_oe;
  endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the scan controller
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] IDENT = 32'h0000_5A5B; // Arbitrary value
  logic clk, arst_n, tck, tms, tdi, tdo, tdo_oe, q, oe, test_mode, run_op, st_reset;
  logic [47:0] cap, chain_out, got;
  logic [2:0] sel;
  logic [7:0] instr;
  logic [7:0] byp [3] = '{8'hFF, 8'h03, 8'h01};
  int errors, num_checks;
  wire tdo_pin = tdo_oe ? tdo : 1'bz;
  scan_tap_controller #(.IDENT_VALUE(IDENT)) scan_tap_controller_i (.CLK(clk), .ARST_N(arst_n), .TCK(tck),
    .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .CHAIN_CAPTURE(cap), .CHAIN_OUT(chain_out),
    .EXTRA_SELECT(sel), .INSTRUCTION(instr), .TEST_MODE(test_mode), .RUN_OPERATION(run_op),
    .STATE_RESET(st_reset));
  scan_host scan_host_i (.clk(clk), .tdo(tdo_pin), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Idle to idle scan; bit brk ends in exit, pause and a resumed shift
  task automatic scan(input logic ir, input logic [47:0] d, input int len, output logic [47:0] so,
    input int brk = -1);
    so = '0;
    scan_host_i.step(1'b1, 1'b1, q, oe);
    if (ir) scan_host_i.step(1'b1, 1'b1, q, oe);
    scan_host_i.step(1'b0, 1'b1, q, oe);
    scan_host_i.step(1'b0, 1'b1, q, oe);
    for (int i = 0; i < len; i++) begin
      scan_host_i.step(logic'(i == len - 1 || i == brk), d[i], q, oe);
      so[i] = q;
      check("tdo enable", oe, 1'b1);
      if (i == brk && i != len - 1) begin
        repeat (3) scan_host_i.step(1'b0, 1'b1, q, oe);
        check("pause float", oe, 1'b0);
        scan_host_i.step(1'b1, 1'b1, q, oe);
        scan_host_i.step(1'b0, 1'b1, q, oe);
      end
    end
    scan_host_i.step(1'b1, 1'b1, q, oe);
    check("tdo float", oe, 1'b0);
    scan_host_i.step(1'b0, 1'b1, q, oe);
    // The last rise reaches the controller state one and a half CLK after the sample
    repeat (2) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
  initial begin
    arst_n = 1'b0;
    cap = 48'h0;
    errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("instruction", instr, 8'h81);
    check("selector", sel, 3'h2);
    check("cells", chain_out[47:44], 4'h3);
    check("reset state", st_reset, 1'b1);
    scan_host_i.step(1'b0, 1'b1, q, oe);
    scan(1'b1, 48'h8B, 8, got, 3);
    check("ir capture", got, 48'h81);
    check("instruction", instr, 8'h8B);
    scan(1'b0, 48'h5, 3, got);
    check("selector capture", got, 48'h2);
    check("selector", sel, 3'h5);
    scan(1'b1, 48'h0A, 8, got);
    scan(1'b0, 48'h3, 3, got);
    check("selector read", got, 48'h5);
    check("selector kept", sel, 3'h5);
    scan(1'b1, 48'h81, 8, got);
    scan(1'b0, 48'h0, 32, got);
    check("ident", got, {16'h0, IDENT});
    foreach (byp[k]) begin
      scan(1'b1, {40'h0, byp[k]}, 8, got);
      scan(1'b0, 48'h3, 2, got);
      check("bypass", got, 48'h2);
    end
    @(posedge clk);
    cap <= 48'h3A5C_F00F_1234;
    scan(1'b1, 48'h82, 8, got);
    scan(1'b0, 48'hC5A5_0FF0_8421, 48, got, 20);
    check("chain capture", got, 48'h3A5C_F00F_1234);
    check("chain out", chain_out, 48'hC5A5_0FF0_8421);
    scan(1'b1, 48'h09, 8, got);
    check("run operation", run_op, 1'b1);
    scan(1'b1, 48'h00, 8, got);
    check("test mode", test_mode, 1'b1);
    repeat (5) scan_host_i.step(1'b1, 1'b1, q, oe);
    check("reset state", st_reset, 1'b1);
    check("test mode", test_mode, 1'b0);
    check("instruction", instr, 8'h81);
    check("cells", chain_out[47:44], 4'h3);
    check("selector", sel, 3'h2);
    print_verdict();
  end
endmodule
